// File: src/mss_bank.sv
// memory size select register bank with capacity limiting
`timescale 1ns/1ps
`default_nettype none
`include "mss_params.svh"
// Behaviour
// - accesses to program memory or high-speed ram beyond the selected size are blocked.
// - reset loads the memory size select register with cf hex.
// - high-speed ram field pattern 110 selects 1024 bytes, others are prohibited.
// - program memory field 1100 selects 48k and 1111 selects 60k, others prohibited.
// - extension ram accesses beyond the selected size are blocked.
// - reset loads the extension ram size select register with 0c hex.
// - the extension ram size select register sits at fff4 hex, bits 7 to 5 read zero.
// - extension ram field 01000 selects 2048 bytes and 01010 selects 1024 bytes.
module mss_bank (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [15:0] addr,
  input wire logic wr_en,
  input wire mss_pkg::mss_byte_t wr_data,
  output logic [7:0] rd_data,
  output logic rd_hit,
  input wire mss_pkg::mss_addr_t rom_addr,
  output logic rom_ok,
  input wire mss_pkg::mss_addr_t hram_addr,
  output logic hram_ok,
  input wire logic [11:0] xram_offs,
  output logic xram_ok,
  output logic [3:0] rom_cap,
  output logic [2:0] hram_cap,
  output logic [4:0] xram_cap
);
  import mss_pkg::*;

  mss_byte_t memory_size_select;
  mss_byte_t ext_ram_size_select;
  mss_if bus();

  mss_decode u_dec (
    .addr(addr),
    .wr_en(wr_en),
    .bus(bus)
  );

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      memory_size_select <= `MSS_RST_MEM;
    end else if (bus.wr_mem) begin
      memory_size_select <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ext_ram_size_select <= `MSS_RST_XRAM;
    end else if (bus.wr_xram) begin
      ext_ram_size_select <= wr_data & `MSS_XRAM_MASK;
    end
  end

  assign rd_hit = bus.sel_mem | bus.sel_xram;
  assign rd_data = bus.sel_mem ? memory_size_select :
                   (bus.sel_xram ? ext_ram_size_select : 8'h00);

  // field views
  assign rom_cap = memory_size_select[`MSS_ROM_LSB +: 4];
  assign hram_cap = memory_size_select[`MSS_HRAM_LSB +: 3];
  assign xram_cap = ext_ram_size_select[4:0];

  // legal pattern decode, one named wire per allowed setting
  logic rom_is_48k;
  logic rom_is_60k;
  logic hram_is_1k;
  logic xram_is_2k;
  logic xram_is_1k;
  assign rom_is_48k = (rom_cap == `MSS_ROM_48K);
  assign rom_is_60k = (rom_cap == `MSS_ROM_60K);
  assign hram_is_1k = (hram_cap == `MSS_HRAM_1K);
  assign xram_is_2k = (xram_cap == `MSS_XRAM_2K);
  assign xram_is_1k = (xram_cap == `MSS_XRAM_1K);

  // program memory limit, prohibited patterns block everything
  // program memory window
  // a prohibited pattern shuts the window rather than guessing a size
  assign rom_ok = rom_is_60k ? (rom_addr <= `MSS_ROM_TOP_60K) :
                  (rom_is_48k ? (rom_addr <= `MSS_ROM_TOP_48K) : 1'b0);

  // high-speed ram window, base and top both checked
  // the window never grows past 1024 bytes
  assign hram_ok = hram_is_1k && (hram_addr >= `MSS_HRAM_BASE) &&
                   (hram_addr <= `MSS_HRAM_TOP);

  // extension ram window
  // the offset counts from the start of extension ram, not a full address
  assign xram_ok = xram_is_2k ? (xram_offs < `MSS_XRAM_LIM_2K) :
                   (xram_is_1k ? (xram_offs < `MSS_XRAM_LIM_1K) : 1'b0);

  // reset values, checked one edge after reset is sampled low
  // reset value of memory size
  a_mem_reset: assert property (@(posedge sys_clk)
    !resetn |=> memory_size_select == 8'hcf)
    else $error("memory size reset wrong");
  a_xram_reset: assert property (@(posedge sys_clk)
    !resetn |=> ext_ram_size_select == 8'h0c)
    else $error("xram size reset wrong");
  // full rom and standard hram after reset
  a_cap_reset: assert property (@(posedge sys_clk)
    !resetn |=> (rom_cap == 4'hf) && (hram_cap == 3'h6))
    else $error("capacity fields wrong after reset");
  // reset xram field is not a legal size
  a_xram_rst_shut: assert property (@(posedge sys_clk)
    !resetn |=> (xram_cap == 5'h0c) && !xram_ok)
    else $error("xram window open after reset");

  // writes, read back and holding
  // upper bits zero
  a_xram_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    ext_ram_size_select[7:5] == 3'h0)
    else $error("xram fixed bits not zero");
  a_xram_wrrd: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus.wr_xram |=> ext_ram_size_select == ($past(wr_data) & 8'h1f))
    else $error("xram write lost");
  a_mem_wrrd: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus.wr_mem |=> memory_size_select == $past(wr_data))
    else $error("memory size write lost");
  a_mem_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    !bus.wr_mem |=> $stable(memory_size_select))
    else $error("memory size changed unwritten");
  a_xram_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    !bus.wr_xram |=> $stable(ext_ram_size_select))
    else $error("xram size changed unwritten");
  a_other_wr: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wr_en && (addr != 16'hfff0) && (addr != 16'hfff4)) |=>
    ($stable(memory_size_select) && $stable(ext_ram_size_select)))
    else $error("stray write changed a register");
  a_mem_dec: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus.wr_mem |-> (wr_en && (addr == 16'hfff0)))
    else $error("memory size strobe misdecoded");
  a_xram_dec: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus.wr_xram |-> (wr_en && (addr == 16'hfff4)))
    else $error("xram strobe misdecoded");
  // memory size read returns last write
  a_mem_rdback: assert property (@(posedge sys_clk) disable iff (!resetn)
    (bus.wr_mem ##1 bus.sel_mem) |-> (rd_data == $past(wr_data)))
    else $error("memory size read back wrong");
  // xram read returns masked last write
  a_xram_rdback: assert property (@(posedge sys_clk) disable iff (!resetn)
    (bus.wr_xram ##1 bus.sel_xram) |-> (rd_data == ($past(wr_data) & 8'h1f)))
    else $error("xram read back wrong");
  a_rd_other: assert property (@(posedge sys_clk) disable iff (!resetn)
    ((addr != 16'hfff0) && (addr != 16'hfff4)) |-> ((rd_data == 8'h00) && !rd_hit))
    else $error("unmapped read not zero");
  // xram address hits, top bits read zero
  a_rd_hit: assert property (@(posedge sys_clk) disable iff (!resetn)
    (addr == 16'hfff4) |-> (rd_hit && (rd_data[7:5] == 3'h0)))
    else $error("xram read hit wrong");
  a_mem_hit: assert property (@(posedge sys_clk) disable iff (!resetn)
    (addr == 16'hfff0) |-> rd_hit)
    else $error("memory size read hit missing");

  // windows against the selected capacities
  // 48k top limit
  a_rom_48k: assert property (@(posedge sys_clk) disable iff (!resetn)
    (rom_cap == 4'hc && rom_addr >= 16'hc000) |-> !rom_ok)
    else $error("rom beyond 48k allowed");
  a_rom_48k_in: assert property (@(posedge sys_clk) disable iff (!resetn)
    (rom_cap == 4'hc && rom_addr <= 16'hbfff) |-> rom_ok)
    else $error("rom inside 48k blocked");
  a_rom_60k: assert property (@(posedge sys_clk) disable iff (!resetn)
    (rom_cap == 4'hf && rom_addr <= 16'hefff) |-> rom_ok)
    else $error("rom inside 60k blocked");
  a_rom_60k_out: assert property (@(posedge sys_clk) disable iff (!resetn)
    (rom_cap == 4'hf && rom_addr >= 16'hf000) |-> !rom_ok)
    else $error("rom beyond 60k allowed");
  a_rom_bad: assert property (@(posedge sys_clk) disable iff (!resetn)
    (rom_cap != 4'hc && rom_cap != 4'hf) |-> !rom_ok)
    else $error("rom allowed on bad pattern");
  a_hram_cap: assert property (@(posedge sys_clk) disable iff (!resetn)
    (hram_cap != 3'h6) |-> !hram_ok)
    else $error("hram allowed on bad pattern");
  a_hram_win: assert property (@(posedge sys_clk) disable iff (!resetn)
    (hram_cap == 3'h6) |->
    (hram_ok == ((hram_addr >= 16'hfb00) && (hram_addr <= 16'hfeff))))
    else $error("hram window wrong");
  // nothing above the high-speed ram top
  a_hram_top: assert property (@(posedge sys_clk) disable iff (!resetn)
    (hram_addr >= 16'hff00) |-> !hram_ok)
    else $error("hram allowed above top");
  // nothing below the high-speed ram base
  a_hram_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    (hram_addr < 16'hfb00) |-> !hram_ok)
    else $error("hram allowed below base");
  a_xram_1k: assert property (@(posedge sys_clk) disable iff (!resetn)
    (xram_cap == 5'h0a) |-> (xram_ok == (xram_offs < 12'h400)))
    else $error("xram 1k limit wrong");
  a_xram_2k: assert property (@(posedge sys_clk) disable iff (!resetn)
    (xram_cap == 5'h08) |-> (xram_ok == (xram_offs < 12'h800)))
    else $error("xram 2k limit wrong");
  a_xram_bad: assert property (@(posedge sys_clk) disable iff (!resetn)
    (xram_cap != 5'h08 && xram_cap != 5'h0a) |-> !xram_ok)
    else $error("xram allowed on bad pattern");
endmodule : mss_bank
`default_nettype wire

// File: src/mss_decode.sv
// address decoder for the two size select registers
`timescale 1ns/1ps
`default_nettype none
`include "mss_params.svh"
module mss_decode (
  input wire logic [15:0] addr,
  input wire logic wr_en,
  mss_if.dec bus
);
  // match each register address, qualify writes
  assign bus.sel_mem = (addr == `MSS_ADDR_MEM);
  assign bus.sel_xram = (addr == `MSS_ADDR_XRAM);
  assign bus.wr_mem = wr_en & bus.sel_mem;
  assign bus.wr_xram = wr_en & bus.sel_xram;
endmodule : mss_decode
`default_nettype wire

// File: src/mss_if.sv
// register write/read carrier between the bank and its decoder
`timescale 1ns/1ps
`default_nettype none
interface mss_if;
  logic wr_mem;
  logic wr_xram;
  logic sel_mem;
  logic sel_xram;
  modport dec(output wr_mem, wr_xram, sel_mem, sel_xram);
  modport bank(input wr_mem, wr_xram, sel_mem, sel_xram);
endinterface : mss_if
`default_nettype wire

// File: src/mss_params.svh
// constants for the memory size select register bank
`ifndef MSS_PARAMS_SVH
`define MSS_PARAMS_SVH
`define MSS_ADDR_W 16
`define MSS_ADDR_XRAM 16'hfff4
`define MSS_ADDR_MEM 16'hfff0
`define MSS_RST_MEM 8'hcf
`define MSS_RST_XRAM 8'h0c
`define MSS_XRAM_MASK 8'h1f
`define MSS_ROM_LSB 0
`define MSS_HRAM_LSB 5
`define MSS_ROM_48K 4'hc
`define MSS_ROM_60K 4'hf
`define MSS_HRAM_1K 3'h6
`define MSS_XRAM_2K 5'h08
`define MSS_XRAM_1K 5'h0a
`define MSS_ROM_TOP_48K 16'hbfff
`define MSS_ROM_TOP_60K 16'hefff
`define MSS_HRAM_BASE 16'hfb00
`define MSS_HRAM_TOP 16'hfeff
`define MSS_XRAM_LIM_2K 12'h800
`define MSS_XRAM_LIM_1K 12'h400
`endif

// File: src/mss_pkg.sv
// types shared by the memory size select bank
`default_nettype none
package mss_pkg;
  typedef logic [7:0] mss_byte_t;
  typedef logic [15:0] mss_addr_t;
endpackage : mss_pkg
`default_nettype wire

// File: verif/memory_size_select_bench.sv
// self-checking bench for the memory size select register bank
`timescale 1ns/1ps
`default_nettype none
module memory_size_select_bench;
  import mss_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic wr_en = 1'b0;
  mss_byte_t wr_data = 8'h00;
  mss_addr_t rom_addr = 16'h0000;
  mss_addr_t hram_addr = 16'h0000;
  logic [11:0] xram_offs = 12'h000;
  logic [7:0] rd_data;
  logic rd_hit, rom_ok, hram_ok, xram_ok;
  logic [3:0] rom_cap;
  logic [2:0] hram_cap;
  logic [4:0] xram_cap;
  logic [7:0] m_mem, m_xr;
  int n_mismatch = 0;
  int checks = 0;
  int i;
  logic [23:0] tbl [12] = '{24'hfff0cc, 24'hfff0cf, 24'hfff000, 24'hfff0ff, 24'hfff02c,
    24'hfff0c3, 24'hfff40a, 24'hfff408, 24'hfff4ff, 24'hfff400, 24'hfff2e8, 24'hfff4e8};
  mss_bank uut (.sys_clk(sys_clk), .resetn(resetn), .addr(addr), .wr_en(wr_en),
    .wr_data(wr_data), .rd_data(rd_data), .rd_hit(rd_hit), .rom_addr(rom_addr),
    .rom_ok(rom_ok), .hram_addr(hram_addr), .hram_ok(hram_ok), .xram_offs(xram_offs),
    .xram_ok(xram_ok), .rom_cap(rom_cap), .hram_cap(hram_cap), .xram_cap(xram_cap));
  // 50 MHz clock
  initial forever #10 sys_clk = ~sys_clk;
  // expected port values from the register model and current inputs
  function automatic logic [23:0] exp_f();
    logic [7:0] rd;
    logic rok, hok, xok, hit;
    hit = (addr == 16'hfff0) || (addr == 16'hfff4);
    rd = (addr == 16'hfff0) ? m_mem : ((addr == 16'hfff4) ? m_xr : 8'h00);
    rok = (m_mem[3:0] == 4'hc) ? (rom_addr < 16'hc000) :
      ((m_mem[3:0] == 4'hf) && (rom_addr < 16'hf000));
    hok = (m_mem[7:5] == 3'h6) && (hram_addr >= 16'hfb00) && (hram_addr <= 16'hfeff);
    xok = (m_xr[4:0] == 5'h08) ? (xram_offs < 12'h800) :
      ((m_xr[4:0] == 5'h0a) && (xram_offs < 12'h400));
    return {rd, hit, rok, hok, xok, m_mem[3:0], m_mem[7:5], m_xr[4:0]};
  endfunction : exp_f
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  // one bus cycle: drive, compare settled outputs, then follow the write in the model
  task automatic step(input logic [15:0] a, input logic w, input logic [7:0] d);
    logic [23:0] got;
    logic [23:0] want;
    @(posedge sys_clk);
    #1;
    addr = a;
    wr_en = w;
    wr_data = d;
    rom_addr = 16'($urandom);
    hram_addr = 16'hf800 + 16'($urandom_range(0, 2047));
    xram_offs = 12'($urandom);
    #5;
    got = {rd_data, rd_hit, rom_ok, hram_ok, xram_ok, rom_cap, hram_cap, xram_cap};
    want = exp_f();
    checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("mismatch t=%0t got %h exp %h", $time, got, want);
    end
    if (w && a == 16'hfff0) m_mem = d;
    if (w && a == 16'hfff4) m_xr = d & 8'h1f;
  endtask : step
  // hold reset low for 16 cycles and load the model's reset values
  task automatic do_reset();
    resetn = 1'b0;
    // drop a write left standing by the last step so it cannot land after release
    wr_en = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    m_mem = 8'hcf;
    m_xr = 8'h0c;
  endtask : do_reset
  // main sequence
  initial begin
    i = $urandom(32'hebc38b40);
    do_reset();
    step(16'hfff0, 1'b0, 8'h00);
    step(16'hfff4, 1'b0, 8'h00);
    foreach (tbl[k]) begin
      step(tbl[k][23:8], 1'b1, tbl[k][7:0]);
      step(tbl[k][23:8], 1'b0, 8'h00);
    end
    for (i = 0; i < 300; i++) begin
      step(16'hfff0 + 16'($urandom_range(0, 7)), 1'($urandom), 8'($urandom));
    end
    do_reset();
    step(16'hfff0, 1'b0, 8'h00);
    step(16'hfff4, 1'b0, 8'h00);
    final_report();
  end
endmodule : memory_size_select_bench
`default_nettype wire
